// ---- logic/ssc_pkg.sv ----
`default_nettype none
package ssc_pkg;

	// register byte offsets on the bus
	localparam logic [7:0] OFF_STATUS      = 8'h00;
	localparam logic [7:0] OFF_CONTROL_ONE = 8'h04;
	localparam logic [7:0] OFF_DATA        = 8'h08;
	localparam logic [7:0] OFF_CONTROL_TWO = 8'h0C;
	localparam logic [7:0] OFF_ADDR_RELOAD = 8'h10;
	localparam logic [7:0] OFF_UNMAPPED    = 8'hFF;

	// serial_status field positions
	localparam int ST_SAMPLE       = 7;
	localparam int ST_EDGE         = 6;
	localparam int ST_DATA_ADDR    = 5;
	localparam int ST_STOP         = 4;
	localparam int ST_START        = 3;
	localparam int ST_DIR          = 2;
	localparam int ST_ADDR_REFRESH = 1;
	localparam int ST_FULL         = 0;

	// serial_control_one field positions
	localparam int C1_COLLISION  = 7;
	localparam int C1_OVERRUN    = 6;
	localparam int C1_ENABLE     = 5;
	localparam int C1_IDLE_LEVEL = 4;

	// serial_control_two field positions, request bits sit in [4:0]
	localparam int C2_GEN_CALL   = 7;
	localparam int C2_ACK_STATUS = 6;
	localparam int C2_ACK_DATA   = 5;

	// reset values
	localparam logic [7:0] STATUS_RESET      = 8'h00;
	localparam logic [7:0] CONTROL_ONE_RESET = 8'h00;
	localparam logic [7:0] CONTROL_TWO_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET        = 8'h00;
	localparam logic [7:0] ADDR_RESET        = 8'h00;

	// port_mode_select codes
	localparam logic [3:0] MODE_SPI_DIV4    = 4'h0;
	localparam logic [3:0] MODE_SPI_DIV16   = 4'h1;
	localparam logic [3:0] MODE_SPI_DIV64   = 4'h2;
	localparam logic [3:0] MODE_SPI_TIMER   = 4'h3;
	localparam logic [3:0] MODE_SPI_SLV_SEL = 4'h4;
	localparam logic [3:0] MODE_SPI_SLV     = 4'h5;
	localparam logic [3:0] MODE_I2C_S7      = 4'h6;
	localparam logic [3:0] MODE_I2C_S10     = 4'h7;
	localparam logic [3:0] MODE_I2C_M       = 4'h8;
	localparam logic [3:0] MODE_I2C_FW      = 4'hB;
	localparam logic [3:0] MODE_I2C_S7_EV   = 4'hE;
	localparam logic [3:0] MODE_I2C_S10_EV  = 4'hF;

	// serial clock half periods in core cycles (divide by 4, 16, 64)
	localparam logic [6:0] HALF_DIV4  = 7'h02;
	localparam logic [6:0] HALF_DIV16 = 7'h08;
	localparam logic [6:0] HALF_DIV64 = 7'h20;
	localparam logic [3:0] BYTE_BITS  = 4'h8;
	localparam logic [3:0] LAST_BIT   = 4'h7;

	typedef enum logic {SSC_IDLE, SSC_SHIFT} ssc_shift_state_t;

	function automatic logic is_spi_master(input logic [3:0] m);
		return m <= MODE_SPI_TIMER;
	endfunction

	function automatic logic is_spi_slave(input logic [3:0] m);
		return (m == MODE_SPI_SLV_SEL) || (m == MODE_SPI_SLV);
	endfunction

	function automatic logic is_i2c_master(input logic [3:0] m);
		return (m == MODE_I2C_M) || (m == MODE_I2C_FW);
	endfunction

	function automatic logic is_i2c_slave(input logic [3:0] m);
		return m inside {MODE_I2C_S7, MODE_I2C_S10, MODE_I2C_S7_EV, MODE_I2C_S10_EV};
	endfunction

	function automatic logic is_ten_bit(input logic [3:0] m);
		return (m == MODE_I2C_S10) || (m == MODE_I2C_S10_EV);
	endfunction

	function automatic logic [6:0] half_period(input logic [3:0] m);
		case (m)
			MODE_SPI_DIV4: return HALF_DIV4;
			MODE_SPI_DIV16: return HALF_DIV16;
			default: return HALF_DIV64;
		endcase
	endfunction

endpackage
`default_nettype wire

// ---- logic/ssc_pin_sync.sv ----
`default_nettype none
module ssc_pin_sync #(
	parameter int             WIDTH       = 3,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input  wire logic             clock,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
		logic [WIDTH-1:0] third;
		logic [WIDTH-1:0] held;
	} ssc_sync_t;

	ssc_sync_t s;
	ssc_sync_t next_s;
	logic [WIDTH-1:0] agree;

	// a bit only moves once the last two stages agree, filtering one-cycle glitches
	always_comb begin
		next_s = s;
		agree = ~(s.second ^ s.third);
		next_s.first = d;
		next_s.second = s.first;
		next_s.third = s.second;
		next_s.held = (s.third & agree) | (s.held & ~agree);
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			s <= '{RESET_VALUE, RESET_VALUE, RESET_VALUE, RESET_VALUE};
		end else begin
			s <= next_s;
		end
	end

	assign q = s.held;
endmodule
`default_nettype wire

// ---- logic/ssc_port.sv ----
// Function
// - spi master samples input at end of bit when sample bit set, else middle
// - in i2c modes the sample bit set disables slew control, clear enables it
// - edge bit with idle level picks which serial clock edge transmits
// - in spi the idle-level bit sets the serial clock resting level
// - i2c data/address flag shows whether last byte was data or address
// - stop-seen flag marks last stop, zero after reset and while disabled
// - start-seen flag marks last start, zero after reset and while disabled
// - i2c slave direction flag holds last matched read/write bit until start/stop/nack
// - i2c master direction flag shows transmit, or-ed with requests gives busy
// - ten-bit slave raises address-refresh flag; address write clears it
// - buffer-full flag is set when a received byte lands, cleared on read
// - i2c transmit keeps buffer-full set until data transmit completes
// - i2c master buffer write outside idle sets write collision and is dropped
// - slave buffer write during transfer sets write collision, software clears it
// - spi slave byte arriving into a full buffer sets overrun and is discarded
// - overrun is only set as spi slave or in i2c, never as spi master
// - port runs spi or i2c, i2c master, multi-master and slave with general call
// - four-bit mode field selects clock divider, slave kind or i2c mode
// - clearing port enable hands the pins back to general purpose use
`default_nettype none
module ssc_port (
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        sck_i,
	input  wire logic        sdi_i,
	input  wire logic        ss_n_i,
	output logic             sck_o,
	output logic             sck_oe,
	output logic             sdo_o,
	output logic             sdo_oe,
	input  wire logic        timer_tick,
	output logic             port_active,
	output logic             slew_limit_enable,
	output logic             clock_release,
	input  wire logic        i2c_start_det,
	input  wire logic        i2c_stop_det,
	input  wire logic        i2c_nack,
	input  wire logic        i2c_addr_match,
	input  wire logic        i2c_rw_bit,
	input  wire logic        i2c_byte_rx,
	input  wire logic [7:0]  i2c_rx_data,
	input  wire logic        i2c_rx_is_data,
	input  wire logic        i2c_tx_done,
	input  wire logic        i2c_ua_event,
	input  wire logic        i2c_req_done,
	input  wire logic        i2c_ack_status,
	output logic             i2c_tx_load,
	output logic      [7:0]  i2c_tx_data,
	output logic             start_request,
	output logic             restart_request,
	output logic             stop_request,
	output logic             receive_request,
	output logic             acknowledge_request,
	output logic             ack_data,
	output logic             gen_call_enable,
	output logic      [7:0]  address_reload_reg
);
	typedef struct packed {
		logic [7:0]                  stat;
		logic [7:0]                  ctl1;
		logic [7:0]                  ctl2;
		logic [7:0]                  buffer;
		logic [7:0]                  shifter;
		logic [7:0]                  addr;
		ssc_pkg::ssc_shift_state_t   spi_st;
		logic [3:0]                  bit_cnt;
		logic [6:0]                  div_cnt;
		logic                        phase;
		logic                        samp;
		logic                        sck_prev;
		logic                        tx_busy;
		logic                        sck_o;
		logic                        sck_oe;
		logic                        sdo_o;
		logic                        sdo_oe;
		logic                        port_active;
		logic                        slew_limit;
		logic                        tx_load;
		logic                        wr_pend;
		logic [7:0]                  wr_addr;
		logic [31:0]                 hrdata;
		logic                        hreadyout;
	} ssc_state_t;

	localparam ssc_state_t STATE_RESET = '{
		stat: ssc_pkg::STATUS_RESET, ctl1: ssc_pkg::CONTROL_ONE_RESET, ctl2: ssc_pkg::CONTROL_TWO_RESET,
		buffer: ssc_pkg::DATA_RESET, addr: ssc_pkg::ADDR_RESET, spi_st: ssc_pkg::SSC_IDLE,
		hreadyout: 1'h1, default: '0};

	ssc_state_t s;
	ssc_state_t next_s;
	logic [2:0] pins;
	logic       sck_s, sdi_s, ss_n_s;
	logic [3:0] mode;
	logic       spi_m, spi_s, i2c_m, i2c_s, i2c_on;
	logic       accept, wr_data, tick, rise, fall, tx_edge, smp_edge;
	logic       spi_busy, i2c_idle, byte_done, in_bit, ss_block;
	logic [7:0] rd, rx_byte;

	// pins come from outside the core clock domain
	ssc_pin_sync #(
		.WIDTH       (3),
		.RESET_VALUE (3'h1)
	) u_pin_sync (
		.clock (clock),
		.rstn  (rstn),
		.d     ({sck_i, sdi_i, ss_n_i}),
		.q     (pins)
	);

	// mode decode from the stored control byte
	assign {sck_s, sdi_s, ss_n_s} = pins;
	assign mode = s.ctl1[3:0];
	assign spi_m = ssc_pkg::is_spi_master(mode);
	assign spi_s = ssc_pkg::is_spi_slave(mode);
	assign i2c_m = ssc_pkg::is_i2c_master(mode);
	assign i2c_s = ssc_pkg::is_i2c_slave(mode);
	assign i2c_on = s.ctl1[ssc_pkg::C1_ENABLE] && (i2c_m || i2c_s);

	always_comb begin
		next_s = s;
		rd = 8'h00;
		rx_byte = 8'h00;
		in_bit = 1'h0;
		byte_done = 1'h0;
		next_s.tx_load = 1'h0;
		next_s.sck_prev = sck_s;
		next_s.ctl2[ssc_pkg::C2_ACK_STATUS] = i2c_ack_status;
		spi_busy = (spi_m && s.spi_st == ssc_pkg::SSC_SHIFT) || (spi_s && s.bit_cnt != 4'h0);
		// idle only with no transmit and no request pending
		i2c_idle = !(s.stat[ssc_pkg::ST_DIR] || (|s.ctl2[4:0]));
		// address phase: decode, read data is registered so it stands in the data phase
		accept = hsel && htrans[1] && hready;
		next_s.wr_pend = accept && hwrite;
		next_s.wr_addr = (haddr[31:8] == 24'h000000) ? haddr[7:0] : ssc_pkg::OFF_UNMAPPED;
		case (haddr[7:0])
			ssc_pkg::OFF_STATUS: rd = s.stat;
			ssc_pkg::OFF_CONTROL_ONE: rd = s.ctl1;
			ssc_pkg::OFF_CONTROL_TWO: rd = s.ctl2;
			ssc_pkg::OFF_DATA: rd = s.buffer;
			ssc_pkg::OFF_ADDR_RELOAD: rd = s.addr;
			default: rd = 8'h00;
		endcase
		if (accept && !hwrite) begin
			next_s.hrdata = (haddr[31:8] == 24'h000000) ? {24'h000000, rd} : 32'h00000000;
			if (haddr == {24'h000000, ssc_pkg::OFF_DATA}) begin
				next_s.stat[ssc_pkg::ST_FULL] = 1'h0;
			end
		end
		// data phase: software writes land first so hardware sets below win
		wr_data = s.wr_pend && s.wr_addr == ssc_pkg::OFF_DATA;
		if (s.wr_pend) begin
			case (s.wr_addr)
				ssc_pkg::OFF_STATUS: next_s.stat[7:6] = hwdata[7:6];
				ssc_pkg::OFF_CONTROL_ONE: next_s.ctl1 = hwdata[7:0];
				ssc_pkg::OFF_CONTROL_TWO: begin
					next_s.ctl2[ssc_pkg::C2_GEN_CALL] = hwdata[7];
					next_s.ctl2[ssc_pkg::C2_ACK_DATA] = hwdata[5];
					// requests cannot be queued behind a busy bus
					if (i2c_idle) begin
						next_s.ctl2[4:0] = hwdata[4:0];
					end
				end
				ssc_pkg::OFF_ADDR_RELOAD: begin
					next_s.addr = hwdata[7:0];
					next_s.stat[ssc_pkg::ST_ADDR_REFRESH] = 1'h0;
				end
				default: ;
			endcase
		end
		// spi master: bit window is two half periods, mid and end edges
		tick = (mode == ssc_pkg::MODE_SPI_TIMER) ? timer_tick : (s.div_cnt == ssc_pkg::half_period(mode) - 7'h01);
		if (s.spi_st == ssc_pkg::SSC_SHIFT) begin
			next_s.div_cnt = tick ? 7'h00 : s.div_cnt + 7'h01;
			if (tick && !s.phase) begin
				next_s.phase = 1'h1;
				next_s.sck_o = s.ctl1[ssc_pkg::C1_IDLE_LEVEL] ^ ~s.stat[ssc_pkg::ST_EDGE];
				if (!s.stat[ssc_pkg::ST_SAMPLE]) begin
					next_s.samp = sdi_s;
				end
			end else if (tick) begin
				in_bit = s.stat[ssc_pkg::ST_SAMPLE] ? sdi_s : s.samp;
				next_s.shifter = {s.shifter[6:0], in_bit};
				next_s.bit_cnt = s.bit_cnt - 4'h1;
				if (s.bit_cnt == 4'h1) begin
					next_s.spi_st = ssc_pkg::SSC_IDLE;
					next_s.sck_o = s.ctl1[ssc_pkg::C1_IDLE_LEVEL];
					byte_done = 1'h1;
					rx_byte = {s.shifter[6:0], in_bit};
				end else begin
					next_s.phase = 1'h0;
					// transmit edge opens the window when edge bit set
					next_s.sck_o = s.ctl1[ssc_pkg::C1_IDLE_LEVEL] ^ s.stat[ssc_pkg::ST_EDGE];
					next_s.sdo_o = s.shifter[6];
				end
			end
		end else if (spi_m) begin
			next_s.sck_o = s.ctl1[ssc_pkg::C1_IDLE_LEVEL];
		end
		// spi slave: edges of the synchronised clock pin
		rise = sck_s && !s.sck_prev;
		fall = !sck_s && s.sck_prev;
		// transmit on rising when exactly one of idle level and edge bit is set
		tx_edge = (s.ctl1[ssc_pkg::C1_IDLE_LEVEL] ^ s.stat[ssc_pkg::ST_EDGE]) ? rise : fall;
		smp_edge = (s.ctl1[ssc_pkg::C1_IDLE_LEVEL] ^ s.stat[ssc_pkg::ST_EDGE]) ? fall : rise;
		ss_block = (mode == ssc_pkg::MODE_SPI_SLV_SEL) && ss_n_s;
		if (spi_s && s.ctl1[ssc_pkg::C1_ENABLE]) begin
			if (ss_block) begin
				next_s.bit_cnt = 4'h0;
			end else begin
				if (tx_edge) begin
					next_s.sdo_o = s.shifter[7];
				end
				if (smp_edge) begin
					next_s.shifter = {s.shifter[6:0], sdi_s};
					next_s.bit_cnt = (s.bit_cnt == ssc_pkg::LAST_BIT) ? 4'h0 : s.bit_cnt + 4'h1;
					byte_done = s.bit_cnt == ssc_pkg::LAST_BIT;
					rx_byte = {s.shifter[6:0], sdi_s};
				end
			end
		end
		// buffer write: load the shifter or hand the byte to the i2c engine
		if (wr_data && s.ctl1[ssc_pkg::C1_ENABLE]) begin
			if ((spi_m || spi_s) && spi_busy) begin
				// write during a transfer is ignored and flagged
				next_s.ctl1[ssc_pkg::C1_COLLISION] = 1'h1;
			end else if (spi_m || spi_s) begin
				next_s.shifter = hwdata[7:0];
				next_s.sdo_o = hwdata[7];
				if (spi_m) begin
					next_s.spi_st = ssc_pkg::SSC_SHIFT;
					next_s.bit_cnt = ssc_pkg::BYTE_BITS;
					next_s.div_cnt = 7'h00;
					next_s.phase = 1'h0;
					next_s.sck_o = s.ctl1[ssc_pkg::C1_IDLE_LEVEL] ^ s.stat[ssc_pkg::ST_EDGE];
				end
			end else if ((i2c_m && !i2c_idle) || (i2c_s && s.tx_busy)) begin
				// bus not ready for a new transmit
				next_s.ctl1[ssc_pkg::C1_COLLISION] = 1'h1;
			end else if (i2c_m || i2c_s) begin
				// buffer stays full while the byte goes out
				next_s.buffer = hwdata[7:0];
				next_s.stat[ssc_pkg::ST_FULL] = 1'h1;
				next_s.tx_busy = 1'h1;
				next_s.tx_load = 1'h1;
				if (i2c_m) begin
					next_s.stat[ssc_pkg::ST_DIR] = 1'h1;
				end
			end
		end
		// received spi byte: as slave a full buffer means the new byte is lost
		if (byte_done) begin
			if (next_s.stat[ssc_pkg::ST_FULL] && spi_s) begin
				next_s.ctl1[ssc_pkg::C1_OVERRUN] = 1'h1;
			end else begin
				next_s.buffer = rx_byte;
				next_s.stat[ssc_pkg::ST_FULL] = 1'h1;
			end
		end
		// i2c engine events, only while the port is on in an i2c mode
		if (i2c_on) begin
			if (i2c_tx_done) begin
				next_s.stat[ssc_pkg::ST_FULL] = 1'h0;
				next_s.stat[ssc_pkg::ST_DATA_ADDR] = 1'h1;
				next_s.tx_busy = 1'h0;
				if (i2c_m) begin
					next_s.stat[ssc_pkg::ST_DIR] = 1'h0;
				end
			end
			// direction stays valid only up to start, stop or nack
			if (i2c_s && (i2c_start_det || i2c_stop_det || i2c_nack)) begin
				next_s.stat[ssc_pkg::ST_DIR] = 1'h0;
			end
			if (i2c_s && i2c_addr_match) begin
				next_s.stat[ssc_pkg::ST_DIR] = i2c_rw_bit;
				next_s.stat[ssc_pkg::ST_DATA_ADDR] = 1'h0;
			end
			if (i2c_start_det) begin
				next_s.stat[ssc_pkg::ST_START] = 1'h1;
				next_s.stat[ssc_pkg::ST_STOP] = 1'h0;
			end
			if (i2c_stop_det) begin
				next_s.stat[ssc_pkg::ST_STOP] = 1'h1;
				next_s.stat[ssc_pkg::ST_START] = 1'h0;
			end
			if (i2c_byte_rx) begin
				next_s.stat[ssc_pkg::ST_DATA_ADDR] = i2c_rx_is_data;
				if (next_s.stat[ssc_pkg::ST_FULL]) begin
					next_s.ctl1[ssc_pkg::C1_OVERRUN] = 1'h1;
				end else begin
					next_s.buffer = i2c_rx_data;
					next_s.stat[ssc_pkg::ST_FULL] = 1'h1;
				end
			end
			if (i2c_ua_event && ssc_pkg::is_ten_bit(mode)) begin
				next_s.stat[ssc_pkg::ST_ADDR_REFRESH] = 1'h1;
			end
			if (i2c_req_done) begin
				next_s.ctl2[4:0] = 5'h00;
			end
		end
		// disabled port: start and stop flags cleared, engine parked
		if (!next_s.ctl1[ssc_pkg::C1_ENABLE]) begin
			next_s.stat[ssc_pkg::ST_START] = 1'h0;
			next_s.stat[ssc_pkg::ST_STOP] = 1'h0;
			next_s.spi_st = ssc_pkg::SSC_IDLE;
			next_s.bit_cnt = 4'h0;
			next_s.tx_busy = 1'h0;
		end
		// pins belong to the port only while enabled
		next_s.port_active = next_s.ctl1[ssc_pkg::C1_ENABLE];
		next_s.sck_oe = next_s.ctl1[ssc_pkg::C1_ENABLE] && ssc_pkg::is_spi_master(next_s.ctl1[3:0]);
		next_s.sdo_oe = next_s.ctl1[ssc_pkg::C1_ENABLE] && !ss_block
			&& (ssc_pkg::is_spi_master(next_s.ctl1[3:0]) || ssc_pkg::is_spi_slave(next_s.ctl1[3:0]));
		// slew limiting in i2c when the sample bit is clear
		next_s.slew_limit = next_s.ctl1[ssc_pkg::C1_ENABLE] && !next_s.stat[ssc_pkg::ST_SAMPLE]
			&& (ssc_pkg::is_i2c_master(next_s.ctl1[3:0]) || ssc_pkg::is_i2c_slave(next_s.ctl1[3:0]));
		next_s.hreadyout = 1'h1;
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			s <= STATE_RESET;
		end else begin
			s <= next_s;
		end
	end

	// outputs straight from the state flops, hresp tied low
	assign hrdata = s.hrdata;
	assign hreadyout = s.hreadyout;
	assign hresp = 1'h0;
	assign sck_o = s.sck_o;
	assign sck_oe = s.sck_oe;
	assign sdo_o = s.sdo_o;
	assign sdo_oe = s.sdo_oe;
	assign port_active = s.port_active;
	assign slew_limit_enable = s.slew_limit;
	assign clock_release = s.ctl1[ssc_pkg::C1_IDLE_LEVEL];
	assign i2c_tx_load = s.tx_load;
	assign i2c_tx_data = s.buffer;
	assign {acknowledge_request, receive_request, stop_request, restart_request, start_request} = s.ctl2[4:0];
	assign ack_data = s.ctl2[ssc_pkg::C2_ACK_DATA];
	assign gen_call_enable = s.ctl2[ssc_pkg::C2_GEN_CALL];
	assign address_reload_reg = s.addr;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	sequence data_write_s;
		s.wr_pend && s.wr_addr == ssc_pkg::OFF_DATA && s.ctl1[ssc_pkg::C1_ENABLE];
	endsequence

	sequence fast_start_s;
		$rose(s.spi_st == ssc_pkg::SSC_SHIFT) && mode == ssc_pkg::MODE_SPI_DIV4;
	endsequence

	rate_divide_a: assert property (fast_start_s |-> ##31 s.spi_st == ssc_pkg::SSC_SHIFT ##1 s.spi_st == ssc_pkg::SSC_IDLE)
		else $error("divide by four transfer length wrong");
	overrun_slave_a: assert property ($rose(s.ctl1[ssc_pkg::C1_OVERRUN]) |-> $past(spi_s) || $past(i2c_on)
		|| $past(s.wr_pend && s.wr_addr == ssc_pkg::OFF_CONTROL_ONE))
		else $error("overrun set outside slave or i2c mode");
	slave_collide_a: assert property (data_write_s and (spi_s && s.bit_cnt != 4'h0) |=> s.ctl1[ssc_pkg::C1_COLLISION])
		else $error("slave collision not flagged");
	master_tx_a: assert property (data_write_s and (i2c_m && i2c_idle) |=> s.stat[ssc_pkg::ST_DIR] && s.tx_load)
		else $error("i2c master transmit not started");
	stop_disable_a: assert property (!s.ctl1[ssc_pkg::C1_ENABLE] |-> !s.stat[ssc_pkg::ST_STOP] && !s.stat[ssc_pkg::ST_START])
		else $error("start or stop flag set while disabled");
	start_cause_a: assert property ($rose(s.stat[ssc_pkg::ST_START]) |-> $past(i2c_start_det))
		else $error("start flag without start event");
	refresh_cause_a: assert property ($rose(s.stat[ssc_pkg::ST_ADDR_REFRESH])
		|-> $past(ssc_pkg::is_ten_bit(mode)))
		else $error("address refresh outside ten-bit mode");
	sck_idle_a: assert property (spi_m && s.spi_st == ssc_pkg::SSC_IDLE ##1 spi_m && s.spi_st == ssc_pkg::SSC_IDLE
		|-> sck_o == $past(s.ctl1[ssc_pkg::C1_IDLE_LEVEL]))
		else $error("serial clock not at idle level");
	pins_off_a: assert property (!port_active |-> !sck_oe && !sdo_oe)
		else $error("pin driven while port disabled");
	data_flag_a: assert property (i2c_on && i2c_byte_rx |=> s.stat[ssc_pkg::ST_DATA_ADDR] == $past(i2c_rx_is_data))
		else $error("data/address flag wrong");
endmodule
`default_nettype wire

// ---- verification/ssc_spi_peer.sv ----
`default_nettype none
module ssc_spi_peer (
	input  wire logic clock,
	output logic      sck,
	output logic      sdi,
	output logic      ss_n
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		sck = 1'b0;
		sdi = 1'b0;
		ss_n = 1'b1;
	end
	// idle low, shift on fall
	// slow halves so the four-flop pin sync keeps up
	task automatic send(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			ss_n <= 1'b0;
			sdi <= b[i];
			repeat (8) @(posedge clock);
			sck <= 1'b1;
			repeat (8) @(posedge clock);
			sck <= 1'b0;
		end
		repeat (8) @(posedge clock);
		ss_n <= 1'b1;
		sdi <= ~sdi; // released line must not hold the last bit
	endtask
endmodule
`default_nettype wire

// ---- verification/sync_serial_status_control_tb.sv ----
`default_nettype none
module sync_serial_status_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic             clock = 0, rstn = 0, hsel = 0, hwrite = 0;
	logic      [1:0]  htrans = 2'h0;
	logic      [31:0] haddr = 32'h0, hwdata = 32'h0, rdat;
	logic      [9:0]  ev = 10'h000;
	wire logic [31:0] hrdata;
	wire logic        hreadyout, sck_o, sdo_o, port_active, slew_limit_enable, clock_release, sck_i, sdi_i, ss_n_i;
	wire logic        sck_oe, sdo_oe;
	wire logic [7:0]  areload, txd;
	logic             tmr_tick = 0, tick_en = 0, ack_st = 0;
	int               failures = 0, cmp_count = 0;
	// event pulses ride in ev, rw and data-kind qualifiers in bits 8 and 9
	ssc_port u_dut (.clock, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
		.hrdata, .hreadyout, .hresp(), .sck_i, .sdi_i, .ss_n_i, .sck_o, .sck_oe, .sdo_o, .sdo_oe,
		.timer_tick(tmr_tick), .port_active, .slew_limit_enable, .clock_release, .i2c_start_det(ev[0]),
		.i2c_stop_det(ev[1]), .i2c_nack(ev[2]), .i2c_addr_match(ev[3]), .i2c_rw_bit(ev[8]), .i2c_byte_rx(ev[4]),
		.i2c_rx_data(8'h5A), .i2c_rx_is_data(ev[9]), .i2c_tx_done(ev[5]), .i2c_ua_event(ev[6]),
		.i2c_req_done(ev[7]), .i2c_ack_status(ack_st), .i2c_tx_load(), .i2c_tx_data(txd), .start_request(),
		.restart_request(), .stop_request(), .receive_request(), .acknowledge_request(), .ack_data(),
		.gen_call_enable(), .address_reload_reg(areload));
	ssc_spi_peer u_peer (.clock, .sck(sck_i), .sdi(sdi_i), .ss_n(ss_n_i));
	always #2.5 clock = ~clock;
	// timer half-period pulse every other cycle while enabled
	always @(posedge clock) tmr_tick <= tick_en & ~tmr_tick;
	task test_done;
		if (failures == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			failures++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	// one single word transfer; never assumes the wait length
	task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clock); while (hreadyout !== 1'b1 && ++n < 50);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hreadyout !== 1'b1 && ++n < 50);
		rdat = hrdata;
		if (n >= 50) begin
			failures++;
			test_done;
		end
	endtask
	task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		chk(rdat & m, e);
	endtask
	task pulse(input logic [9:0] m);
		ev <= m;
		@(posedge clock);
		ev <= 10'h000;
		@(posedge clock);
	endtask
	// poll buffer full under a bound
	task wfull;
		int k;
		rdat = 32'h0;
		for (k = 0; k < 60 && rdat[0] !== 1'b1; k++)
			bus(ssc_pkg::OFF_STATUS, 1'b0, 32'h0);
		if (k == 60) begin
			failures++;
			test_done;
		end
	endtask
	task t_reset;
		rc(ssc_pkg::OFF_STATUS, 32'hFFFFFFFF, {24'h0, ssc_pkg::STATUS_RESET});
		rc(ssc_pkg::OFF_CONTROL_ONE, 32'hFFFFFFFF, {24'h0, ssc_pkg::CONTROL_ONE_RESET});
		bus(ssc_pkg::OFF_UNMAPPED, 1'b1, 32'hFF);
		rc(ssc_pkg::OFF_UNMAPPED, 32'hFFFFFFFF, 32'h0);
	endtask
	task t_master;
		bus(ssc_pkg::OFF_STATUS, 1'b1, 32'hFF);
		rc(ssc_pkg::OFF_STATUS, 32'hFF, 32'hC0);
		bus(ssc_pkg::OFF_STATUS, 1'b1, 32'h0);
		bus(ssc_pkg::OFF_CONTROL_ONE, 1'b1, 32'h20);
		chk({31'h0, sck_o}, 32'h0);
		bus(ssc_pkg::OFF_DATA, 1'b1, 32'hA5);
		bus(ssc_pkg::OFF_DATA, 1'b1, 32'h11);
		chk({31'h0, sdo_o}, 32'h1);
		wfull;
		rc(ssc_pkg::OFF_CONTROL_ONE, 32'hFF, 32'hA0);
		bus(ssc_pkg::OFF_DATA, 1'b0, 32'h0);
		bus(ssc_pkg::OFF_CONTROL_ONE, 1'b1, 32'h23);
		tick_en <= 1'b1;
		bus(ssc_pkg::OFF_DATA, 1'b1, 32'h5A);
		wfull;
		rc(ssc_pkg::OFF_CONTROL_ONE, 32'hFF, 32'h23);
		tick_en <= 1'b0;
		bus(ssc_pkg::OFF_DATA, 1'b0, 32'h0);
		bus(ssc_pkg::OFF_CONTROL_ONE, 1'b1, 32'h30);
		repeat (3) @(posedge clock);
		chk({28'h0, sck_oe, sdo_oe, sck_o, clock_release}, 32'hF);
	endtask
	// sample bit kept clear as slave
	task t_slave;
		bus(ssc_pkg::OFF_CONTROL_ONE, 1'b1, 32'h25);
		// buffer write lands in the middle of the slave frame
		fork
			u_peer.send(8'h3C);
			begin
				repeat (40) @(posedge clock);
				bus(ssc_pkg::OFF_DATA, 1'b1, 32'h77);
			end
		join
		rc(ssc_pkg::OFF_STATUS, 32'hFF, 32'h01);
		rc(ssc_pkg::OFF_CONTROL_ONE, 32'hFF, 32'hA5);
		u_peer.send(8'hC3);
		rc(ssc_pkg::OFF_CONTROL_ONE, 32'hFF, 32'hE5);
		rc(ssc_pkg::OFF_DATA, 32'hFF, 32'h3C);
		rc(ssc_pkg::OFF_STATUS, 32'hFF, 32'h00);
		bus(ssc_pkg::OFF_CONTROL_ONE, 1'b1, 32'h25);
		rc(ssc_pkg::OFF_CONTROL_ONE, 32'hFF, 32'h25);
	endtask
	task t_i2c;
		bus(ssc_pkg::OFF_CONTROL_ONE, 1'b1, 32'h26);
		ack_st <= 1'b1;
		pulse(10'h001);
		rc(ssc_pkg::OFF_STATUS, 32'hFF, 32'h08);
		rc(ssc_pkg::OFF_CONTROL_TWO, 32'h40, 32'h40);
		pulse(10'h108);
		rc(ssc_pkg::OFF_STATUS, 32'h04, 32'h04);
		pulse(10'h210);
		rc(ssc_pkg::OFF_STATUS, 32'h21, 32'h21);
		rc(ssc_pkg::OFF_DATA, 32'hFF, 32'h5A);
		pulse(10'h002);
		rc(ssc_pkg::OFF_STATUS, 32'h19, 32'h10);
		chk({30'h0, port_active, slew_limit_enable}, 32'h3);
		bus(ssc_pkg::OFF_STATUS, 1'b1, 32'h80);
		@(posedge clock);
		chk({31'h0, slew_limit_enable}, 32'h0);
		bus(ssc_pkg::OFF_CONTROL_ONE, 1'b1, 32'h06);
		rc(ssc_pkg::OFF_STATUS, 32'h18, 32'h0);
		chk({31'h0, port_active}, 32'h0);
		bus(ssc_pkg::OFF_CONTROL_ONE, 1'b1, 32'h27);
		pulse(10'h040);
		rc(ssc_pkg::OFF_STATUS, 32'h02, 32'h02);
		bus(ssc_pkg::OFF_ADDR_RELOAD, 1'b1, 32'h3C);
		rc(ssc_pkg::OFF_STATUS, 32'h02, 32'h0);
		chk({24'h0, areload}, 32'h3C);
		bus(ssc_pkg::OFF_CONTROL_ONE, 1'b1, 32'h28);
		// a pending start request makes the port busy
		bus(ssc_pkg::OFF_CONTROL_TWO, 1'b1, 32'h01);
		bus(ssc_pkg::OFF_DATA, 1'b1, 32'h33);
		rc(ssc_pkg::OFF_CONTROL_ONE, 32'h80, 32'h80);
		pulse(10'h080);
		bus(ssc_pkg::OFF_CONTROL_ONE, 1'b1, 32'h28);
		bus(ssc_pkg::OFF_DATA, 1'b1, 32'h11);
		rc(ssc_pkg::OFF_STATUS, 32'h05, 32'h05);
		chk({24'h0, txd}, 32'h11);
		bus(ssc_pkg::OFF_DATA, 1'b1, 32'h22);
		rc(ssc_pkg::OFF_CONTROL_ONE, 32'hFF, 32'hA8);
		pulse(10'h020);
		rc(ssc_pkg::OFF_STATUS, 32'h05, 32'h0);
	endtask
	initial begin
		repeat (5) @(posedge clock);
		rstn <= 1'b1;
		t_reset;
		t_master;
		t_slave;
		t_i2c;
		test_done;
	end
endmodule
`default_nettype wire
